//--- ppfs_top.sv
// Purpose: function select for port 0 pins 0-1 and port 1 pins 0-1
// Assumes: peripherals on core_clk; pads arrive asynchronously
// Notes:   slot numbers per pin are listed beside the decode table
//
// What this block does
// - six-bit select field; zero leaves pin Hi-Z
// - P0.0 pwm U, cmtw3 capture, serial9 receive
// - P0.0 clock ref, conv1 start, serial12, comparator0_output
// - P0.1 pwm W, comparator1, serial9 transmit
// - P0.1 pwm triggers A-D, enable input, conv2
// - P1.0 pwm V, cmtw3 capture, serial9, pwm3 A
// - P1.0 timer reset, enable input, serial6 flow
// - P1.1 phase count, cmtw3 compare, serial clocks
// - P1.1 timer out, enable 9, mtimer9 D, pwm3 B
// - interrupt select bit gates pin to interrupt
// - P0.0 to irq2, P0.1 to irq4 on packages of 64 pins or more
// - P1.0 to irq0, P1.1 to irq1
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module ppfs_top #(
	parameter int PKG_PINS = 100 // package pin count
) (
	input  wire logic                                 core_clk,  // 50 MHz clock
	input  wire logic                                 reset_n,   // async reset
	input  wire logic [ppfs_pkg::ADDR_W-1:0]          reg_addr,  // register index
	input  wire logic [ppfs_pkg::DATA_W-1:0]          reg_wdata, // write data
	input  wire logic                                 reg_wr,    // write strobe
	input  wire logic                                 reg_rd,    // read strobe
	output logic      [ppfs_pkg::DATA_W-1:0]          reg_rdata, // read data
	input  wire logic [ppfs_pkg::NPIN-1:0]            pad_in,    // pad levels
	output logic      [ppfs_pkg::NPIN-1:0]            pad_out,   // pad values
	output logic      [ppfs_pkg::NPIN-1:0]            pad_oe,    // pad enables
	input  wire ppfs_pkg::ppfs_slots_t [ppfs_pkg::NPIN-1:0] fn_out, // periph drive
	input  wire ppfs_pkg::ppfs_slots_t [ppfs_pkg::NPIN-1:0] fn_oe,  // periph enable
	output ppfs_pkg::ppfs_slots_t [ppfs_pkg::NPIN-1:0]      fn_in,  // to periph
	output logic                                      ext_irq0,  // from P1.0
	output logic                                      ext_irq1,  // from P1.1
	output logic                                      ext_irq2,  // from P0.0
	output logic                                      ext_irq4   // from P0.1
);
	import ppfs_pkg::*;

	// =========================================================
	// storage
	logic [DATA_W-1:0] pfs [NPIN];
	logic [NPIN-1:0]   pad_meta;
	logic [NPIN-1:0]   pad_sync;
	logic [NPIN-1:0]   next_pad_out;
	logic [NPIN-1:0]   next_pad_oe;
	ppfs_slots_t [NPIN-1:0] next_fn_in;
	logic [NPIN-1:0]   interrupt_input_select;

	localparam logic P01_IRQ_OK = (PKG_PINS >= P01_IRQ_MIN_PINS);

	// =========================================================
	// selection codes, shared by several pins except 0x08, 0x0A, 0x2D and 0x2E
	localparam logic [SEL_W-1:0] C_MT_IO      = 6'h01;
	localparam logic [SEL_W-1:0] C_MT_CLK     = 6'h02;
	localparam logic [SEL_W-1:0] C_MT_IO_N    = 6'h03;
	localparam logic [SEL_W-1:0] C_MT_CLK_N   = 6'h04;
	localparam logic [SEL_W-1:0] C_TMR8       = 6'h05;
	localparam logic [SEL_W-1:0] C_REF_OE     = 6'h07;
	localparam logic [SEL_W-1:0] C_MT9_IO_D   = 6'h08;
	localparam logic [SEL_W-1:0] C_CONV_START = 6'h09;
	localparam logic [SEL_W-1:0] C_SER6_FLOW  = 6'h0A;
	localparam logic [SEL_W-1:0] C_SER12      = 6'h0C;
	localparam logic [SEL_W-1:0] C_PWM_GRP_A  = 6'h14;
	localparam logic [SEL_W-1:0] C_PWM_GRP_B  = 6'h15;
	localparam logic [SEL_W-1:0] C_PWM_GRP_C  = 6'h16;
	localparam logic [SEL_W-1:0] C_PWM_GRP_D  = 6'h17;
	localparam logic [SEL_W-1:0] C_PWM_PHASE  = 6'h18;
	localparam logic [SEL_W-1:0] C_CMTW3      = 6'h1D;
	localparam logic [SEL_W-1:0] C_COMP       = 6'h1E;
	localparam logic [SEL_W-1:0] C_SER9       = 6'h2C;
	localparam logic [SEL_W-1:0] C_SER8_CLK   = 6'h2D;
	localparam logic [SEL_W-1:0] C_SER9_TX2   = 6'h2E;

	// =========================================================
	// slot numbers, per pin; slot 0 is no function
	// port 0 pin 0
	localparam logic [SLOT_W-1:0] S00_MT9_IO_A    = 5'h01;
	localparam logic [SLOT_W-1:0] S00_MT9_IO_A_N  = 5'h02;
	localparam logic [SLOT_W-1:0] S00_CLK_REF     = 5'h03;
	localparam logic [SLOT_W-1:0] S00_CONV1_START = 5'h04;
	localparam logic [SLOT_W-1:0] S00_SER12_RX    = 5'h05;
	localparam logic [SLOT_W-1:0] S00_PWM_U_IN    = 5'h06;
	localparam logic [SLOT_W-1:0] S00_CMTW3_CAP   = 5'h07;
	localparam logic [SLOT_W-1:0] S00_COMPARATOR0_OUTPUT_OUT   = 5'h08;
	localparam logic [SLOT_W-1:0] S00_SER9_RX     = 5'h09;

	// port 0 pin 1
	localparam logic [SLOT_W-1:0] S01_MT_IO       = 5'h01;
	localparam logic [SLOT_W-1:0] S01_MT_IO_N     = 5'h02;
	localparam logic [SLOT_W-1:0] S01_OE_IN12     = 5'h03;
	localparam logic [SLOT_W-1:0] S01_CONV2_START = 5'h04;
	localparam logic [SLOT_W-1:0] S01_SER12_TX    = 5'h05;
	localparam logic [SLOT_W-1:0] S01_PWM_TRG_A   = 5'h06;
	localparam logic [SLOT_W-1:0] S01_PWM_TRG_B   = 5'h07;
	localparam logic [SLOT_W-1:0] S01_PWM_TRG_C   = 5'h08;
	localparam logic [SLOT_W-1:0] S01_PWM_TRG_D   = 5'h09;
	localparam logic [SLOT_W-1:0] S01_PWM_W_IN    = 5'h0A;
	localparam logic [SLOT_W-1:0] S01_COMPARATOR1_OUTPUT_OUT   = 5'h0B;
	localparam logic [SLOT_W-1:0] S01_SER9_TX     = 5'h0C;

	// port 1 pin 0
	localparam logic [SLOT_W-1:0] S10_MT_IO       = 5'h01;
	localparam logic [SLOT_W-1:0] S10_MT_CLK      = 5'h02;
	localparam logic [SLOT_W-1:0] S10_MT_IO_N     = 5'h03;
	localparam logic [SLOT_W-1:0] S10_MT_CLK_N    = 5'h04;
	localparam logic [SLOT_W-1:0] S10_TMR8_RST    = 5'h05;
	localparam logic [SLOT_W-1:0] S10_OE_IN12     = 5'h06;
	localparam logic [SLOT_W-1:0] S10_SER6_FLOW   = 5'h07;
	localparam logic [SLOT_W-1:0] S10_PWM3_IO_A   = 5'h08;
	localparam logic [SLOT_W-1:0] S10_PWM_TRG_B   = 5'h09;
	localparam logic [SLOT_W-1:0] S10_PWM3_IO_A_N = 5'h0A;
	localparam logic [SLOT_W-1:0] S10_PWM_TRG_D   = 5'h0B;
	localparam logic [SLOT_W-1:0] S10_PWM_V_IN    = 5'h0C;
	localparam logic [SLOT_W-1:0] S10_CMTW3_CAP   = 5'h0D;
	localparam logic [SLOT_W-1:0] S10_SER9_TX     = 5'h0E;

	// port 1 pin 1
	localparam logic [SLOT_W-1:0] S11_MT_IO       = 5'h01;
	localparam logic [SLOT_W-1:0] S11_MT_CLK      = 5'h02;
	localparam logic [SLOT_W-1:0] S11_MT_IO_N     = 5'h03;
	localparam logic [SLOT_W-1:0] S11_MT_CLK_N    = 5'h04;
	localparam logic [SLOT_W-1:0] S11_TMR8_OUT    = 5'h05;
	localparam logic [SLOT_W-1:0] S11_OE_IN9      = 5'h06;
	localparam logic [SLOT_W-1:0] S11_MT9_IO_D    = 5'h07;
	localparam logic [SLOT_W-1:0] S11_PWM3_IO_B   = 5'h08;
	localparam logic [SLOT_W-1:0] S11_PWM_TRG_A   = 5'h09;
	localparam logic [SLOT_W-1:0] S11_PWM3_IO_B_N = 5'h0A;
	localparam logic [SLOT_W-1:0] S11_PWM_TRG_C   = 5'h0B;
	localparam logic [SLOT_W-1:0] S11_PWM_PHASE0  = 5'h0C;
	localparam logic [SLOT_W-1:0] S11_CMTW3_CMP   = 5'h0D;
	localparam logic [SLOT_W-1:0] S11_SER9_CLK    = 5'h0E;
	localparam logic [SLOT_W-1:0] S11_SER8_CLK    = 5'h0F;
	localparam logic [SLOT_W-1:0] S11_SER9_TX2    = 5'h10;

	// =========================================================
	// decode helpers
	function automatic ppfs_dec_s mk(
		input logic [SLOT_W-1:0] s,
		input ppfs_kind_e        k
	);
		ppfs_dec_s r;
		r.slot = s;
		r.kind = k;
		return r;
	endfunction

	function automatic logic is_pfs(input logic [ADDR_W-1:0] a);
		return a == OFS_P00 || a == OFS_P01 || a == OFS_P10 || a == OFS_P11;
	endfunction

	// per-pin code tables; unlisted codes fall to no function
	function automatic ppfs_dec_s dec_p00(input logic [SEL_W-1:0] code);
		ppfs_dec_s d;
		case (code)
			C_MT_IO:      d = mk(S00_MT9_IO_A, K_IO);
			C_MT_IO_N:    d = mk(S00_MT9_IO_A_N, K_IO);
			C_REF_OE:     d = mk(S00_CLK_REF, K_IN);
			C_CONV_START: d = mk(S00_CONV1_START, K_OUT);
			C_SER12:      d = mk(S00_SER12_RX, K_IO);
			C_PWM_PHASE:  d = mk(S00_PWM_U_IN, K_IN);
			C_CMTW3:      d = mk(S00_CMTW3_CAP, K_IN);
			C_COMP:       d = mk(S00_COMPARATOR0_OUTPUT_OUT, K_OUT);
			C_SER9:       d = mk(S00_SER9_RX, K_IO);
			default:      d = mk(SLOT_NONE, K_NONE);
		endcase
		return d;
	endfunction

	function automatic ppfs_dec_s dec_p01(input logic [SEL_W-1:0] code);
		ppfs_dec_s d;
		case (code)
			C_MT_IO:      d = mk(S01_MT_IO, K_IO);
			C_MT_IO_N:    d = mk(S01_MT_IO_N, K_IO);
			C_REF_OE:     d = mk(S01_OE_IN12, K_IN);
			C_CONV_START: d = mk(S01_CONV2_START, K_OUT);
			C_SER12:      d = mk(S01_SER12_TX, K_IO);
			C_PWM_GRP_A:  d = mk(S01_PWM_TRG_A, K_IN);
			C_PWM_GRP_B:  d = mk(S01_PWM_TRG_B, K_IN);
			C_PWM_GRP_C:  d = mk(S01_PWM_TRG_C, K_IN);
			C_PWM_GRP_D:  d = mk(S01_PWM_TRG_D, K_IN);
			C_PWM_PHASE:  d = mk(S01_PWM_W_IN, K_IN);
			C_COMP:       d = mk(S01_COMPARATOR1_OUTPUT_OUT, K_OUT);
			C_SER9:       d = mk(S01_SER9_TX, K_IO);
			default:      d = mk(SLOT_NONE, K_NONE);
		endcase
		return d;
	endfunction

	function automatic ppfs_dec_s dec_p10(input logic [SEL_W-1:0] code);
		ppfs_dec_s d;
		case (code)
			C_MT_IO:      d = mk(S10_MT_IO, K_IO);
			C_MT_CLK:     d = mk(S10_MT_CLK, K_IN);
			C_MT_IO_N:    d = mk(S10_MT_IO_N, K_IO);
			C_MT_CLK_N:   d = mk(S10_MT_CLK_N, K_IN);
			C_TMR8:       d = mk(S10_TMR8_RST, K_IN);
			C_REF_OE:     d = mk(S10_OE_IN12, K_IN);
			C_SER6_FLOW:  d = mk(S10_SER6_FLOW, K_IO);
			C_PWM_GRP_A:  d = mk(S10_PWM3_IO_A, K_IO);
			C_PWM_GRP_B:  d = mk(S10_PWM_TRG_B, K_IN);
			C_PWM_GRP_C:  d = mk(S10_PWM3_IO_A_N, K_IO);
			C_PWM_GRP_D:  d = mk(S10_PWM_TRG_D, K_IN);
			C_PWM_PHASE:  d = mk(S10_PWM_V_IN, K_IN);
			C_CMTW3:      d = mk(S10_CMTW3_CAP, K_IN);
			C_SER9:       d = mk(S10_SER9_TX, K_IO);
			default:      d = mk(SLOT_NONE, K_NONE);
		endcase
		return d;
	endfunction

	function automatic ppfs_dec_s dec_p11(input logic [SEL_W-1:0] code);
		ppfs_dec_s d;
		case (code)
			C_MT_IO:      d = mk(S11_MT_IO, K_IO);
			C_MT_CLK:     d = mk(S11_MT_CLK, K_IN);
			C_MT_IO_N:    d = mk(S11_MT_IO_N, K_IO);
			C_MT_CLK_N:   d = mk(S11_MT_CLK_N, K_IN);
			C_TMR8:       d = mk(S11_TMR8_OUT, K_OUT);
			C_REF_OE:     d = mk(S11_OE_IN9, K_IN);
			C_MT9_IO_D:   d = mk(S11_MT9_IO_D, K_IO);
			C_PWM_GRP_A:  d = mk(S11_PWM3_IO_B, K_IO);
			C_PWM_GRP_B:  d = mk(S11_PWM_TRG_A, K_IN);
			C_PWM_GRP_C:  d = mk(S11_PWM3_IO_B_N, K_IO);
			C_PWM_GRP_D:  d = mk(S11_PWM_TRG_C, K_IN);
			C_PWM_PHASE:  d = mk(S11_PWM_PHASE0, K_OUT);
			C_CMTW3:      d = mk(S11_CMTW3_CMP, K_OUT);
			C_SER9:       d = mk(S11_SER9_CLK, K_IO);
			C_SER8_CLK:   d = mk(S11_SER8_CLK, K_IO);
			C_SER9_TX2:   d = mk(S11_SER9_TX2, K_OUT);
			default:      d = mk(SLOT_NONE, K_NONE);
		endcase
		return d;
	endfunction

	// selection code to slot, per pin
	function automatic ppfs_dec_s decode(
		input logic [1:0]       pin,
		input logic [SEL_W-1:0] code
	);
		ppfs_dec_s d;
		case (pin)
			PIN_P00: d = dec_p00(code);
			PIN_P01: d = dec_p01(code);
			PIN_P10: d = dec_p10(code);
			PIN_P11: d = dec_p11(code);
			default: d = mk(SLOT_NONE, K_NONE);
		endcase
		return d;
	endfunction

	// =========================================================
	// register writes
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NPIN; i++) begin
				pfs[i] <= PFS_RST;
			end
		end else if (reg_wr && is_pfs(reg_addr)) begin
			pfs[reg_addr[1:0]] <= reg_wdata & PFS_MASK;
		end
	end

	// =========================================================
	// register reads, valid in the cycle after the strobe only
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= '0;
		end else if (reg_rd && is_pfs(reg_addr)) begin
			reg_rdata <= pfs[reg_addr[1:0]];
		end else if (reg_rd && reg_addr == OFS_STATUS) begin
			reg_rdata <= '0;
			reg_rdata[STAT_PIN_LSB +: NPIN] <= pad_sync;
			reg_rdata[STAT_IRQ_LSB +: NPIN] <= {ext_irq4, ext_irq2, ext_irq1, ext_irq0};
		end else begin
			reg_rdata <= '0;
		end
	end

	// =========================================================
	// pad synchroniser
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pad_meta <= '0;
			pad_sync <= '0;
		end else begin
			pad_meta <= pad_in;
			pad_sync <= pad_meta;
		end
	end

	// =========================================================
	// per-pin routing
	for (genvar p = 0; p < NPIN; p++) begin : g_pin
		ppfs_sel_if u_if ();
		ppfs_dec_s  dec;

		assign dec = decode(2'(p), pfs[p][SEL_LSB +: SEL_W]);
		assign u_if.slot    = dec.slot;
		assign u_if.kind    = dec.kind;
		assign u_if.pin_lvl = pad_sync[p];
		assign u_if.fn_out  = fn_out[p];
		assign u_if.fn_oe   = fn_oe[p];
		assign next_pad_out[p] = u_if.pad_d;
		assign next_pad_oe[p]  = u_if.pad_en;
		assign next_fn_in[p]   = u_if.fn_in;
		assign interrupt_input_select[p]         = pfs[p][INTERRUPT_INPUT_SELECT_BIT];

		ppfs_pin_mux u_mux (
			.sel (u_if.mux)
		);
	end

	// =========================================================
	// registered pad and peripheral side
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pad_out <= '0;
			pad_oe  <= '0;
			fn_in   <= '0;
		end else begin
			pad_out <= next_pad_out;
			pad_oe  <= next_pad_oe;
			fn_in   <= next_fn_in;
		end
	end

	// =========================================================
	// external interrupt lines
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ext_irq0 <= 1'b0;
			ext_irq1 <= 1'b0;
			ext_irq2 <= 1'b0;
			ext_irq4 <= 1'b0;
		end else begin
			ext_irq2 <= interrupt_input_select[PIN_P00] & pad_sync[PIN_P00];
			ext_irq4 <= interrupt_input_select[PIN_P01] & pad_sync[PIN_P01] & P01_IRQ_OK;
			ext_irq0 <= interrupt_input_select[PIN_P10] & pad_sync[PIN_P10];
			ext_irq1 <= interrupt_input_select[PIN_P11] & pad_sync[PIN_P11];
		end
	end
endmodule // ppfs_top

`default_nettype wire

//--- ppfs_pkg.sv
// Purpose: shared constants and types of the port 0/1 function select block
// Assumes: 8-bit register port, four pins, six-bit selection codes
// Notes:   slot 0 of every pin means no function connected
`default_nettype none

package ppfs_pkg;
	// =========================================================
	// sizes
	localparam int NPIN   = 4;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int SEL_W  = 6;
	localparam int NSLOT  = 17;
	localparam int SLOT_W = 5;

	// =========================================================
	// register layout
	localparam int SEL_LSB      = 0;
	localparam int INTERRUPT_INPUT_SELECT_BIT     = 6;
	localparam int STAT_PIN_LSB = 0;
	localparam int STAT_IRQ_LSB = 4;
	localparam logic [DATA_W-1:0] PFS_RST  = 8'h00;
	localparam logic [DATA_W-1:0] PFS_MASK = 8'h7F;
	localparam logic [SEL_W-1:0]  SEL_HIZ  = 6'h00;
	localparam logic [SLOT_W-1:0] SLOT_NONE = 5'h00;

	localparam logic [ADDR_W-1:0] OFS_P00    = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_P01    = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_P10    = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_P11    = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h4;

	// pin indices, equal to the low address bits of their register
	localparam logic [1:0] PIN_P00 = 2'h0;
	localparam logic [1:0] PIN_P01 = 2'h1;
	localparam logic [1:0] PIN_P10 = 2'h2;
	localparam logic [1:0] PIN_P11 = 2'h3;

	// least package pin count that offers the port 0 pin 1 interrupt
	localparam int P01_IRQ_MIN_PINS = 64;

	// =========================================================
	// types
	typedef enum logic [1:0] {K_NONE, K_IN, K_OUT, K_IO} ppfs_kind_e;

	typedef struct packed {
		logic [SLOT_W-1:0] slot;
		ppfs_kind_e        kind;
	} ppfs_dec_s;

	typedef logic [NSLOT-1:0] ppfs_slots_t;
endpackage

`default_nettype wire

//--- ppfs_sel_if.sv
// Purpose: carrier between the select block top and one pin multiplexer
// Assumes: one instance per pin
// Notes:   all signals are on core_clk
`timescale 1ns/1ps
`default_nettype none

interface ppfs_sel_if;
	import ppfs_pkg::*;
	logic [SLOT_W-1:0] slot;    // decoded function slot
	ppfs_kind_e        kind;    // direction class of the slot
	logic              pin_lvl; // synchronised pad level
	ppfs_slots_t       fn_out;  // peripheral drive values
	ppfs_slots_t       fn_oe;   // peripheral drive requests
	logic              pad_d;   // next pad value
	logic              pad_en;  // next pad enable
	ppfs_slots_t       fn_in;   // next level toward peripherals

	modport top (output slot, kind, pin_lvl, fn_out, fn_oe,
		input pad_d, pad_en, fn_in);
	modport mux (input slot, kind, pin_lvl, fn_out, fn_oe,
		output pad_d, pad_en, fn_in);
endinterface

`default_nettype wire

//--- ppfs_pin_mux.sv
// Purpose: route one pin between its selected peripheral slot and the pad
// Assumes: slot and kind already decoded from the selection code
// Notes:   purely combinational; the top registers every result
`timescale 1ns/1ps
`default_nettype none

module ppfs_pin_mux (
	ppfs_sel_if.mux sel // one pin's routing signals
);
	import ppfs_pkg::*;

	// =========================================================
	// pad drive
	always_comb begin
		sel.pad_d  = sel.fn_out[sel.slot];
		sel.pad_en = 1'b0;
		case (sel.kind)
			K_OUT:   sel.pad_en = 1'b1;
			K_IO:    sel.pad_en = sel.fn_oe[sel.slot];
			default: sel.pad_en = 1'b0;
		endcase
	end

	// =========================================================
	// level back to the selected peripheral only
	always_comb begin
		sel.fn_in = '0;
		if ((sel.kind == K_IN || sel.kind == K_IO) && sel.slot != SLOT_NONE) begin
			sel.fn_in[sel.slot] = sel.pin_lvl;
		end
	end
endmodule // ppfs_pin_mux

`default_nettype wire

//--- ppfs_top_properties.sv
// Purpose: concurrent checks on the ports of the function select block
// Assumes: one clock domain, reset_n asynchronous active low
// Notes:   attached by bind after the module
`timescale 1ns/1ps
`default_nettype none

module ppfs_top_properties (
	input wire logic                                   core_clk,  // clock
	input wire logic                                   reset_n,   // reset
	input wire logic [ppfs_pkg::ADDR_W-1:0]            reg_addr,  // index
	input wire logic [ppfs_pkg::DATA_W-1:0]            reg_wdata, // write data
	input wire logic                                   reg_wr,    // write strobe
	input wire logic                                   reg_rd,    // read strobe
	input wire logic [ppfs_pkg::DATA_W-1:0]            reg_rdata, // read data
	input wire logic [ppfs_pkg::NPIN-1:0]              pad_in,    // pad levels
	input wire logic [ppfs_pkg::NPIN-1:0]              pad_oe,    // pad enables
	input wire ppfs_pkg::ppfs_slots_t [ppfs_pkg::NPIN-1:0] fn_in, // to periph
	input wire logic                                   ext_irq0,  // from P1.0
	input wire logic                                   ext_irq1,  // from P1.1
	input wire logic                                   ext_irq2,  // from P0.0
	input wire logic                                   ext_irq4   // from P0.1
);
	import ppfs_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	// ==========================================================
	// register port
	sequence s_pin_wr;
		reg_wr && reg_addr < 3'h4;
	endsequence
	sequence s_same_rd;
		reg_rd && reg_addr == $past(reg_addr);
	endsequence
	property p_readback;
		s_pin_wr ##1 s_same_rd |=> reg_rdata == ($past(reg_wdata, 2) & PFS_MASK);
	endproperty
	property p_rd_idle;
		!reg_rd |=> reg_rdata == 8'h00;
	endproperty
	property p_rd_bit7;
		reg_rd && reg_addr < 3'h4 |=> !reg_rdata[7];
	endproperty
	property p_rd_unmapped;
		reg_rd && reg_addr > 3'h4 |=> reg_rdata == 8'h00;
	endproperty
	a_readback: assert property (p_readback) else $error("pin register readback wrong");
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
	a_rd_bit7: assert property (p_rd_bit7) else $error("pin register bit 7 not zero");
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

	// ==========================================================
	// pin routing
	property p_one_slot;
		$onehot0(fn_in[0]) && $onehot0(fn_in[1]) && $onehot0(fn_in[2]) && $onehot0(fn_in[3]);
	endproperty
	property p_reset_quiet;
		$rose(reset_n) |-> pad_oe == 4'h0 && fn_in == '0;
	endproperty
	a_one_slot: assert property (p_one_slot) else $error("more than one slot fed");
	a_reset_quiet: assert property (p_reset_quiet) else $error("pins active after reset");

	// ==========================================================
	// interrupt lines follow their pad
	property p_irq(logic irq, logic pad);
		$rose(irq) |-> $past(pad, 2) || $past(pad, 3) || $past(pad, 4);
	endproperty
	a_irq0: assert property (p_irq(ext_irq0, pad_in[2])) else $error("irq0 source wrong");
	a_irq1: assert property (p_irq(ext_irq1, pad_in[3])) else $error("irq1 source wrong");
	a_irq2: assert property (p_irq(ext_irq2, pad_in[0])) else $error("irq2 source wrong");
	a_irq4: assert property (p_irq(ext_irq4, pad_in[1])) else $error("irq4 source wrong");
endmodule // ppfs_top_properties

bind ppfs_top ppfs_top_properties u_ppfs_top_properties (.core_clk, .reset_n, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pad_in, .pad_oe, .fn_in, .ext_irq0,
	.ext_irq1, .ext_irq2, .ext_irq4);

`default_nettype wire

//--- ppfs_top_tb_top.sv
// Purpose: self-checking bench for the function select block
// Assumes: default package pin count
// Notes:   each pin case drives only the selected slot and expects it alone
`timescale 1ns/1ps
`default_nettype none

module ppfs_top_tb_top;
	import ppfs_pkg::*;
	logic                    core_clk = 1'b0;
	logic                    reset_n = 1'b0;
	logic [ADDR_W-1:0]       reg_addr = 3'h0;
	logic [DATA_W-1:0]       reg_wdata = 8'h00;
	logic                    reg_wr = 1'b0;
	logic                    reg_rd = 1'b0;
	logic [DATA_W-1:0]       reg_rdata;
	logic [NPIN-1:0]         pad_in = 4'h0;
	logic [NPIN-1:0]         pad_out;
	logic [NPIN-1:0]         pad_oe;
	ppfs_slots_t [NPIN-1:0]  fn_out = '0;
	ppfs_slots_t [NPIN-1:0]  fn_oe = '0;
	ppfs_slots_t [NPIN-1:0]  fn_in;
	logic                    ext_irq0, ext_irq1, ext_irq2, ext_irq4;
	int                      num_errors = 0;
	int                      checks = 0;

	always #10 core_clk = ~core_clk;

	ppfs_top u_ppfs_top (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .pad_in, .pad_out, .pad_oe, .fn_out, .fn_oe, .fn_in, .ext_irq0,
		.ext_irq1, .ext_irq2, .ext_irq4);

	// ==========================================================
	// helpers
	task automatic complete_run;
		if (num_errors == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
	endtask

	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		cyc(1'b0, 1'b1, a, 8'h00);
		cyc(1'b0, 1'b0, a, 8'h00);
		#1 check(17'(reg_rdata), 17'(exp));
	endtask

	task automatic settle;
		repeat (4) @(posedge core_clk);
		#1;
	endtask

	// ==========================================================
	// scenarios
	task automatic reg_test;
		for (int i = 0; i < 4; i++) rd_chk(3'(i), PFS_RST);
		rd_chk(3'h5, 8'h00);
		cyc(1'b1, 1'b0, 3'h0, 8'hFF);
		rd_chk(3'h0, 8'h7F);
		@(posedge core_clk);
		#1 check(17'(reg_rdata), 17'h00000);
		cyc(1'b1, 1'b0, 3'h0, 8'h00);
	endtask

	task automatic run_case(input logic [1:0] p, input logic [5:0] code,
		input logic [SLOT_W-1:0] slot, input ppfs_kind_e k);
		logic drv;
		drv = (k == K_OUT || k == K_IO);
		cyc(1'b1, 1'b0, {1'b0, p}, {2'h0, code});
		fn_out[p] <= 17'h00001 << slot;
		fn_oe[p] <= 17'h00001 << slot;
		pad_in[p] <= 1'b1;
		cyc(1'b0, 1'b0, 3'h0, 8'h00);
		settle();
		check(17'({pad_oe[p], pad_out[p] & drv}), 17'({drv, drv}));
		check(fn_in[p], (k == K_IN || k == K_IO) ? 17'h00001 << slot : 17'h00000);
		@(posedge core_clk);
		fn_out[p] <= '0;
		fn_oe[p] <= '0;
		pad_in[p] <= 1'b0;
		settle();
		check(17'({pad_oe[p], pad_out[p] & drv}), 17'({k == K_OUT, 1'b0}));
		check(fn_in[p], 17'h00000);
	endtask

	task automatic irq_test;
		pad_in <= 4'hF;
		for (int i = 0; i < 4; i++) cyc(1'b1, 1'b0, 3'(i), 8'h40);
		cyc(1'b0, 1'b0, 3'h0, 8'h00);
		settle();
		check(17'({ext_irq4, ext_irq2, ext_irq1, ext_irq0}), 17'h0000F);
		rd_chk(OFS_STATUS, 8'hFF);
		cyc(1'b1, 1'b0, 3'h0, 8'h00);
		cyc(1'b1, 1'b0, 3'h2, 8'h58);
		cyc(1'b0, 1'b0, 3'h0, 8'h00);
		settle();
		check(17'({ext_irq4, ext_irq2, ext_irq1, ext_irq0}), 17'h0000B);
		rd_chk(OFS_STATUS, 8'hBF);
		@(posedge core_clk);
		pad_in <= 4'h0;
		settle();
		check(17'({ext_irq4, ext_irq2, ext_irq1, ext_irq0}), 17'h00000);
		rd_chk(OFS_STATUS, 8'h00);
		for (int i = 0; i < 4; i++) cyc(1'b1, 1'b0, 3'(i), 8'h00);
		cyc(1'b0, 1'b0, 3'h0, 8'h00);
	endtask

	// ==========================================================
	// main sequence and watchdog
	initial begin
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
		reg_test();
		irq_test();
		run_case(2'h0, 6'h00, 5'h00, K_NONE);
		run_case(2'h0, 6'h18, 5'h06, K_IN);
		run_case(2'h0, 6'h1D, 5'h07, K_IN);
		run_case(2'h0, 6'h2C, 5'h09, K_IO);
		run_case(2'h0, 6'h07, 5'h03, K_IN);
		run_case(2'h0, 6'h09, 5'h04, K_OUT);
		run_case(2'h0, 6'h0C, 5'h05, K_IO);
		run_case(2'h0, 6'h1E, 5'h08, K_OUT);
		run_case(2'h0, 6'h01, 5'h01, K_IO);
		run_case(2'h1, 6'h18, 5'h0A, K_IN);
		run_case(2'h1, 6'h1E, 5'h0B, K_OUT);
		run_case(2'h1, 6'h2C, 5'h0C, K_IO);
		run_case(2'h1, 6'h14, 5'h06, K_IN);
		run_case(2'h1, 6'h17, 5'h09, K_IN);
		run_case(2'h1, 6'h07, 5'h03, K_IN);
		run_case(2'h1, 6'h09, 5'h04, K_OUT);
		run_case(2'h2, 6'h18, 5'h0C, K_IN);
		run_case(2'h2, 6'h1D, 5'h0D, K_IN);
		run_case(2'h2, 6'h2C, 5'h0E, K_IO);
		run_case(2'h2, 6'h16, 5'h0A, K_IO);
		run_case(2'h2, 6'h05, 5'h05, K_IN);
		run_case(2'h2, 6'h0A, 5'h07, K_IO);
		run_case(2'h2, 6'h17, 5'h0B, K_IN);
		run_case(2'h2, 6'h07, 5'h06, K_IN);
		run_case(2'h3, 6'h18, 5'h0C, K_OUT);
		run_case(2'h3, 6'h1D, 5'h0D, K_OUT);
		run_case(2'h3, 6'h2D, 5'h0F, K_IO);
		run_case(2'h3, 6'h2E, 5'h10, K_OUT);
		run_case(2'h3, 6'h05, 5'h05, K_OUT);
		run_case(2'h3, 6'h07, 5'h06, K_IN);
		run_case(2'h3, 6'h08, 5'h07, K_IO);
		run_case(2'h3, 6'h14, 5'h08, K_IO);
		run_case(2'h0, 6'h02, 5'h00, K_NONE);
		run_case(2'h3, 6'h3F, 5'h00, K_NONE);
		complete_run();
	end

	initial begin
		#100000;
		num_errors++;
		complete_run();
	end
endmodule // ppfs_top_tb_top

`default_nettype wire
